// ### rtl/rtc_evt_defs.vh
// Constants for the RTC event flag and backup transfer slice
`ifndef RTC_EVT_DEFS_VH
`define RTC_EVT_DEFS_VH

// Register offsets (byte addresses, one aligned word each)
`define RTC_OFS_EVENT_FLAG     8'h00
`define RTC_OFS_EVENT_ENABLE   8'h04
`define RTC_OFS_XFER_CTRL      8'h08
`define RTC_OFS_STATUS         8'h0C
`define RTC_OFS_ALARM_VALUE    8'h10
`define RTC_OFS_ALARM_CMP_EN   8'h14
`define RTC_OFS_ALARM_CMP_HI   8'h18

// Event flag bit positions
`define RTC_BIT_READ_DONE      7
`define RTC_BIT_REWRITE_ERR    6
`define RTC_BIT_ALARM          5
`define RTC_BIT_TIMER_UF       4
`define RTC_BIT_HOURLY         3
`define RTC_BIT_MINUTELY       2
`define RTC_BIT_PER_SECOND     1
`define RTC_BIT_HALF_SECOND    0

// Transfer control strobe positions
`define RTC_BIT_PORT_SAVE      5
`define RTC_BIT_PORT_RECALL    4
`define RTC_BIT_BACKUP_SAVE    3
`define RTC_BIT_BACKUP_RECALL  2
`define RTC_BIT_SETTING_SAVE   1
`define RTC_BIT_SETTING_RECALL 0

// Reset values
`define RTC_RST_EVENT_FLAG     8'h00
`define RTC_RST_EVENT_ENABLE   8'h00
`define RTC_RST_ALARM          40'h00_0000_0000
`define RTC_RST_ALARM_EN       5'h00

// Alarm field count (year, month, day, hour, minute)
`define RTC_ALARM_FIELDS       5

`endif

// ### rtl/rtc_alarm_cmp.v
// Per-field alarm compare with individual compare enables
`timescale 1ns/1ps
`default_nettype none
`include "rtc_evt_defs.vh"

module rtc_alarm_cmp (
    input  wire        i_clk,       // System clock
    input  wire        i_rst,       // Async reset, active high
    input  wire [39:0] i_alarm,     // Alarm fields, 8 bits each
    input  wire [39:0] i_count,     // Running counters, same layout
    input  wire [4:0]  i_cmp_en,    // Per-field compare enable
    output wire        o_match_rise // One-cycle pulse on new match
);

    wire [4:0] field_ok;
    reg        match_ff;
    wire       nxt_match;

    // Disabled fields always agree
    genvar g;
    generate
        for (g = 0; g < `RTC_ALARM_FIELDS; g = g + 1) begin : g_field
            assign field_ok[g] = ~i_cmp_en[g] | (i_alarm[g*8 +: 8] == i_count[g*8 +: 8]);
        end
    endgenerate

    // No enabled field means no alarm at all
    assign nxt_match = (&field_ok) & (|i_cmp_en);

    // Edge only, so a lasting match sets the flag once
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            match_ff <= 1'b0;
        end else begin
            match_ff <= nxt_match;
        end
    end

    assign o_match_rise = nxt_match & ~match_ff;

endmodule
`default_nettype wire

// ### rtl/rtc_event_ctrl.v
// RTC event flags, interrupt enables and domain transfer strobes
//
// Notes on behaviour
// - Read-done flag set after recall copy completes
// - Flags read one during read-modify-write read
// - Write zero clears flag, one keeps it
// - Rewrite error when second fails to count
// - Alarm flag when enabled fields match counters
// - Timer underflow sets flag bit four
// - Hour increment sets hourly flag
// - Minute increment sets minutely flag
// - Second increment sets per-second flag
// - Half-second pulse sets flag bit zero
// - Enable bits mirror flag positions
// - Port save strobe starts save
// - Port recall strobe starts recall
// - Backup save strobe starts save
// - Backup recall strobe starts recall
// - Setting save strobe starts transfer
// - Setting recall strobe starts transfer
// - Setting strobes ignored with oscillator stopped
// - Reserved and strobe bits read zero
// - Setting save clears pending, reflects buffers
// - Only enabled alarm fields are compared
`timescale 1ns/1ps
`default_nettype none
`include "rtc_evt_defs.vh"

module rtc_event_ctrl (
    input  wire        i_clk,               // 10 MHz bus clock
    input  wire        i_rst,               // Async reset, active high
    input  wire [7:0]  i_addr,              // Register byte address
    input  wire [31:0] i_wdata,             // Write data
    input  wire        i_wr,                // Write strobe
    input  wire        i_rd,                // Read strobe
    input  wire        i_rmw,               // Read is the read half of a read-modify-write
    output reg  [31:0] o_rdata,             // Read data, cycle after read strobe
    input  wire        i_recall_copy_done,  // Pulse: counters copied to readable registers
    input  wire        i_second_pulse_detect_stop, // Second-pulse detection stopped
    input  wire        i_time_rewrite,      // Time rewrite in progress
    input  wire        i_second_tick,       // Pulse: second counter counted up
    input  wire        i_minute_tick,       // Pulse: minute counter counted up
    input  wire        i_hour_tick,         // Pulse: hour counter counted up
    input  wire        i_half_second_tick,  // Pulse: half-second pulse
    input  wire        i_timer_underflow,   // Pulse: interval timer underflow
    input  wire        i_rewrite_window_end,// Pulse: rewrite check point passed
    input  wire [39:0] i_count_value,       // Running year..minute counters
    input  wire        i_sub_osc_stopped,   // Async: sub-oscillator stopped
    input  wire        i_xfer_busy,         // Battery side still copying
    output reg         o_port_save,         // Pulse: start port save
    output reg         o_port_recall,       // Pulse: start port recall
    output reg         o_backup_save,       // Pulse: start backup save
    output reg         o_backup_recall,     // Pulse: start backup recall
    output reg         o_setting_save,      // Pulse: start setting save
    output reg         o_setting_recall,    // Pulse: start setting recall
    output reg         o_transfer_pending,  // Setting transfer in flight
    output wire        o_irq                // Interrupt request, level
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    reg  [7:0]  event_flag_ff;
    reg  [7:0]  event_enable_ff;
    reg  [39:0] alarm_value_ff;
    reg  [4:0]  alarm_cmp_en_ff;
    reg  [2:0]  osc_sync_ff;
    reg         osc_stopped_ff;
    reg  [7:0]  nxt_event_flag;
    reg  [7:0]  set_vec;
    reg  [7:0]  clr_vec;
    reg  [31:0] nxt_rdata;
    reg         second_seen_ff;
    wire        alarm_rise;
    wire        wr_flag;
    wire        wr_enable;
    wire        wr_xfer;
    wire        setting_ok;

    ////////////////////////////////////////////////////////////////////
    // Address decode

    assign wr_flag   = i_wr & (i_addr == `RTC_OFS_EVENT_FLAG);
    assign wr_enable = i_wr & (i_addr == `RTC_OFS_EVENT_ENABLE);
    assign wr_xfer   = i_wr & (i_addr == `RTC_OFS_XFER_CTRL);

    ////////////////////////////////////////////////////////////////////
    // Sub-oscillator status synchroniser

    // Pin input; count a change only when stages two and three agree
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            osc_sync_ff    <= 3'h0;
            osc_stopped_ff <= 1'b0;
        end else begin
            osc_sync_ff <= {osc_sync_ff[1:0], i_sub_osc_stopped};
            if (osc_sync_ff[1] == osc_sync_ff[2]) begin
                osc_stopped_ff <= osc_sync_ff[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alarm compare

    rtc_alarm_cmp u_alarm_cmp (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_alarm      (alarm_value_ff),
        .i_count      (i_count_value),
        .i_cmp_en     (alarm_cmp_en_ff),
        .o_match_rise (alarm_rise)
    );

    ////////////////////////////////////////////////////////////////////
    // Rewrite error detection

    // Remember whether the second counted while detection was stopped
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            second_seen_ff <= 1'b0;
        end else if (!(i_time_rewrite & i_second_pulse_detect_stop)) begin
            second_seen_ff <= 1'b0;
        end else if (i_second_tick) begin
            second_seen_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event flags

    // Hardware sets win over a same-cycle software clear
    always @* begin
        set_vec = 8'h00;
        set_vec[`RTC_BIT_READ_DONE]   = i_recall_copy_done;
        set_vec[`RTC_BIT_REWRITE_ERR] = i_time_rewrite & i_second_pulse_detect_stop
                                      & i_rewrite_window_end & ~second_seen_ff
                                      & ~i_second_tick;
        set_vec[`RTC_BIT_ALARM]       = alarm_rise;
        set_vec[`RTC_BIT_TIMER_UF]    = i_timer_underflow;
        set_vec[`RTC_BIT_HOURLY]      = i_hour_tick;
        set_vec[`RTC_BIT_MINUTELY]    = i_minute_tick;
        set_vec[`RTC_BIT_PER_SECOND]  = i_second_tick;
        set_vec[`RTC_BIT_HALF_SECOND] = i_half_second_tick;
        clr_vec = wr_flag ? ~i_wdata[7:0] : 8'h00;
        nxt_event_flag = (event_flag_ff & ~clr_vec) | set_vec;
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            event_flag_ff <= `RTC_RST_EVENT_FLAG;
        end else begin
            event_flag_ff <= nxt_event_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Enables and alarm configuration

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            event_enable_ff <= `RTC_RST_EVENT_ENABLE;
            alarm_value_ff  <= `RTC_RST_ALARM;
            alarm_cmp_en_ff <= `RTC_RST_ALARM_EN;
        end else begin
            if (wr_enable) begin
                event_enable_ff <= i_wdata[7:0];
            end
            if (i_wr && (i_addr == `RTC_OFS_ALARM_VALUE)) begin
                alarm_value_ff[31:0] <= i_wdata;
            end
            if (i_wr && (i_addr == `RTC_OFS_ALARM_CMP_HI)) begin
                alarm_value_ff[39:32] <= i_wdata[7:0];
            end
            if (i_wr && (i_addr == `RTC_OFS_ALARM_CMP_EN)) begin
                alarm_cmp_en_ff <= i_wdata[4:0];
            end
        end
    end

    // Level request, drops as soon as no enabled flag remains
    assign o_irq = |(event_flag_ff & event_enable_ff);

    ////////////////////////////////////////////////////////////////////
    // Transfer strobes

    // Setting transfers need the sub-oscillator running
    assign setting_ok = ~osc_stopped_ff;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_port_save      <= 1'b0;
            o_port_recall    <= 1'b0;
            o_backup_save    <= 1'b0;
            o_backup_recall  <= 1'b0;
            o_setting_save   <= 1'b0;
            o_setting_recall <= 1'b0;
        end else begin
            // Writing zero to any strobe is a no-op
            o_port_save      <= wr_xfer & i_wdata[`RTC_BIT_PORT_SAVE];
            o_port_recall    <= wr_xfer & i_wdata[`RTC_BIT_PORT_RECALL];
            o_backup_save    <= wr_xfer & i_wdata[`RTC_BIT_BACKUP_SAVE];
            o_backup_recall  <= wr_xfer & i_wdata[`RTC_BIT_BACKUP_RECALL];
            o_setting_save   <= wr_xfer & i_wdata[`RTC_BIT_SETTING_SAVE] & setting_ok;
            o_setting_recall <= wr_xfer & i_wdata[`RTC_BIT_SETTING_RECALL] & setting_ok;
        end
    end

    // Pending goes low once a setting save is taken; buffers then flow out
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_transfer_pending <= 1'b0;
        end else if (wr_xfer && i_wdata[`RTC_BIT_SETTING_SAVE] && setting_ok) begin
            o_transfer_pending <= 1'b0;
        end else begin
            o_transfer_pending <= i_xfer_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path

    // Unmapped addresses read zero; strobes and reserved bits read zero
    always @* begin
        nxt_rdata = 32'h0000_0000;
        if (i_addr == `RTC_OFS_EVENT_FLAG) begin
            nxt_rdata[7:0] = i_rmw ? 8'hFF : event_flag_ff;
        end else if (i_addr == `RTC_OFS_EVENT_ENABLE) begin
            nxt_rdata[7:0] = event_enable_ff;
        end else if (i_addr == `RTC_OFS_XFER_CTRL) begin
            nxt_rdata = 32'h0000_0000;
        end else if (i_addr == `RTC_OFS_STATUS) begin
            nxt_rdata[1:0] = {o_transfer_pending, osc_stopped_ff};
        end else if (i_addr == `RTC_OFS_ALARM_VALUE) begin
            nxt_rdata = alarm_value_ff[31:0];
        end else if (i_addr == `RTC_OFS_ALARM_CMP_EN) begin
            nxt_rdata[4:0] = alarm_cmp_en_ff;
        end else if (i_addr == `RTC_OFS_ALARM_CMP_HI) begin
            nxt_rdata[7:0] = alarm_value_ff[39:32];
        end
    end

    // Data stands only in the cycle after the read strobe
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= nxt_rdata;
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// ### tb/batt_domain_model.sv
// Behavioural battery-backed domain answering setting transfers
`timescale 1ns/1ps
`default_nettype none
module batt_domain_model (
    input  wire logic i_clk,            // Bus clock
    input  wire logic i_rst,            // Async reset
    input  wire logic i_setting_save,   // Save start pulse
    input  wire logic i_setting_recall, // Recall start pulse
    output var  logic o_xfer_busy,      // Copy in flight
    output var  logic o_copy_done       // Recall copy finished
);
    logic [1:0] left_ff;   // Copy cycles left
    logic       recall_ff; // Copy direction
    // Fixed three-cycle copy, short on purpose to keep the run brief
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            left_ff <= 2'h0;
            recall_ff <= 1'b0;
            o_copy_done <= 1'b0;
        end else begin
            o_copy_done <= recall_ff && (left_ff == 2'h1);
            if (i_setting_save || i_setting_recall) begin
                left_ff <= 2'h3;
                recall_ff <= i_setting_recall;
            end else if (left_ff != 2'h0) begin
                left_ff <= left_ff - 2'h1;
            end
        end
    end
    // Busy level seen by the pending indication
    assign o_xfer_busy = (left_ff != 2'h0);
endmodule
`default_nettype wire

// ### tb/rtc_event_ctrl_props.sv
// Port-level assertions for the event flag and transfer slice
`timescale 1ns/1ps
`default_nettype none
`include "rtc_evt_defs.vh"
module rtc_event_ctrl_props (
    input wire logic        i_clk,              // Bus clock
    input wire logic        i_rst,              // Async reset
    input wire logic [7:0]  i_addr,             // Address
    input wire logic [31:0] i_wdata,            // Write data
    input wire logic        i_wr,               // Write strobe
    input wire logic        i_rd,               // Read strobe
    input wire logic        i_rmw,              // Read half of RMW
    input wire logic [31:0] o_rdata,            // Read data
    input wire logic        o_port_save,        // Strobe out
    input wire logic        o_port_recall,      // Strobe out
    input wire logic        o_backup_save,      // Strobe out
    input wire logic        o_backup_recall,    // Strobe out
    input wire logic        o_setting_save,     // Strobe out
    input wire logic        o_setting_recall,   // Strobe out
    input wire logic        o_transfer_pending  // Pending level
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Write to the transfer control register
    wire xw = i_wr && (i_addr == `RTC_OFS_XFER_CTRL);
    port_save_pulse_a: assert property (o_port_save == $past(xw && i_wdata[5]))
        else $error("port save strobe wrong");
    port_recall_start_a: assert property (xw && i_wdata[4] |=> o_port_recall)
        else $error("port recall strobe missing");
    backup_save_cause_a: assert property (o_backup_save |-> $past(xw && i_wdata[3]))
        else $error("backup save strobe without write");
    backup_recall_zero_a: assert property (xw && !i_wdata[2] |=> !o_backup_recall)
        else $error("backup recall on zero write");
    setting_save_cause_a: assert property (o_setting_save |-> $past(xw && i_wdata[1]))
        else $error("setting save strobe without write");
    setting_recall_cause_a: assert property (o_setting_recall |-> $past(xw && i_wdata[0]))
        else $error("setting recall strobe without write");
    pending_forced_low_a: assert property (o_setting_save |-> !o_transfer_pending)
        else $error("pending high after setting save");
    xfer_reads_zero_a: assert property (i_rd && i_addr == `RTC_OFS_XFER_CTRL |=> o_rdata == 32'h0)
        else $error("transfer control read not zero");
    rmw_flags_one_a: assert property (i_rd && i_rmw && i_addr == `RTC_OFS_EVENT_FLAG |=> &o_rdata[7:0])
        else $error("modify read of flags not all ones");
    rdata_idle_zero_a: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data outside read cycle");
    cover property (xw && i_wdata[0] ##1 o_setting_recall);
    cover property (i_rd && i_rmw);
    cover property (o_transfer_pending);
endmodule
bind rtc_event_ctrl rtc_event_ctrl_props rtc_event_ctrl_props_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_rmw(i_rmw), .o_rdata(o_rdata), .o_port_save(o_port_save),
    .o_port_recall(o_port_recall), .o_backup_save(o_backup_save), .o_backup_recall(o_backup_recall),
    .o_setting_save(o_setting_save), .o_setting_recall(o_setting_recall),
    .o_transfer_pending(o_transfer_pending));
`default_nettype wire

// ### tb/tb.sv
// Testbench for the RTC event flag and transfer slice
`timescale 1ns/1ps
`default_nettype none
`include "rtc_evt_defs.vh"
module tb;
    logic        i_clk = 1'b0;                // 10 MHz clock
    logic        i_rst = 1'b1;                // Reset
    logic [7:0]  i_addr = 8'h00;              // Address
    logic [31:0] i_wdata = 32'h0;             // Write data
    logic        i_wr = 1'b0;                 // Write strobe
    logic        i_rd = 1'b0;                 // Read strobe
    logic        i_rmw = 1'b0;                // RMW read marker
    logic [4:0]  ev = 5'h00;                  // Event pulses in flag order
    logic        second_pulse_detect_stop = 1'b0;                 // Second detect stopped
    logic        rewr = 1'b0;                 // Time rewrite
    logic        wend = 1'b0;                 // Rewrite window end
    logic        osc = 1'b0;                  // Oscillator stopped
    logic [39:0] cnt = 40'h0;                 // Counters
    wire  [31:0] o_rdata;                     // Read data
    wire  [5:0]  stb;                         // Strobes in register order
    wire         pend, o_irq, busy, done;     // Status lines
    int          miscompares = 0;
    int          samples_checked = 0;
    int          b;
    always #50 i_clk = ~i_clk;
    rtc_event_ctrl rtc_event_ctrl_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .i_rmw(i_rmw), .o_rdata(o_rdata), .i_recall_copy_done(done),
        .i_second_pulse_detect_stop(second_pulse_detect_stop), .i_time_rewrite(rewr), .i_second_tick(ev[1]),
        .i_minute_tick(ev[2]), .i_hour_tick(ev[3]), .i_half_second_tick(ev[0]),
        .i_timer_underflow(ev[4]), .i_rewrite_window_end(wend), .i_count_value(cnt),
        .i_sub_osc_stopped(osc), .i_xfer_busy(busy), .o_port_save(stb[5]),
        .o_port_recall(stb[4]), .o_backup_save(stb[3]), .o_backup_recall(stb[2]),
        .o_setting_save(stb[1]), .o_setting_recall(stb[0]), .o_transfer_pending(pend), .o_irq(o_irq));
    batt_domain_model batt_domain_model_inst (.i_clk(i_clk), .i_rst(i_rst), .i_setting_save(stb[1]),
        .i_setting_recall(stb[0]), .o_xfer_busy(busy), .o_copy_done(done));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One-cycle write; strobe outputs are settled on return
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    // Read, then compare the data standing in the following cycle
    task automatic rc(input logic [7:0] a, input logic m, input logic [31:0] exp, input string nm);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_rmw <= m;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        i_rmw <= 1'b0;
        #1;
        chk(nm, exp, o_rdata);
    endtask
    task automatic tick(input int n);
        @(posedge i_clk);
        ev[n] <= 1'b1;
        @(posedge i_clk);
        ev[n] <= 1'b0;
        #1;
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog, about 10000 cycles against under two hundred expected
    initial begin
        #1000000;
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        rc(`RTC_OFS_EVENT_FLAG, 1'b0, 32'h0, "flags reset");
        rc(`RTC_OFS_EVENT_ENABLE, 1'b0, 32'h0, "enables reset");
        rc(`RTC_OFS_XFER_CTRL, 1'b0, 32'h0, "xfer read");
        rc(8'h1C, 1'b0, 32'h0, "unmapped read");
        rc(`RTC_OFS_EVENT_FLAG, 1'b1, 32'hFF, "rmw read");
        for (b = 0; b < 5; b++) begin
            tick(b);
            rc(`RTC_OFS_EVENT_FLAG, 1'b0, (32'h2 << b) - 32'h1, "event flag");
        end
        wr(`RTC_OFS_EVENT_FLAG, 32'hFF);
        rc(`RTC_OFS_EVENT_FLAG, 1'b0, 32'h1F, "ones keep");
        for (b = 0; b < 5; b++) begin
            wr(`RTC_OFS_EVENT_FLAG, ~(32'h1 << b));
            rc(`RTC_OFS_EVENT_FLAG, 1'b0, 32'h1F & ~((32'h2 << b) - 32'h1), "zero clears");
        end
        wr(`RTC_OFS_EVENT_ENABLE, 32'h02);
        chk("irq idle", 32'h0, {31'h0, o_irq});
        tick(1);
        chk("irq set", 32'h1, {31'h0, o_irq});
        rc(`RTC_OFS_EVENT_ENABLE, 1'b0, 32'h02, "enable read");
        wr(`RTC_OFS_EVENT_ENABLE, 32'h0);
        chk("irq masked", 32'h0, {31'h0, o_irq});
        wr(`RTC_OFS_EVENT_ENABLE, 32'h02);
        wr(`RTC_OFS_EVENT_FLAG, 32'hFD);
        chk("irq cleared", 32'h0, {31'h0, o_irq});
        // Each strobe alone, spaced so transfers never overlap
        for (b = 0; b < 6; b++) begin
            wr(`RTC_OFS_XFER_CTRL, 32'h1 << b);
            chk("strobes", 32'h1 << b, {26'h0, stb});
            if (b == 1) begin
                chk("pending", 32'h0, {31'h0, pend});
                // Battery side busy reaches pending two edges after the strobe
                repeat (2) @(posedge i_clk);
                #1;
                chk("pending busy", 32'h1, {31'h0, pend});
            end
            repeat (6) @(posedge i_clk);
        end
        wr(`RTC_OFS_XFER_CTRL, 32'h0);
        chk("zero write", 32'h0, {26'h0, stb});
        rc(`RTC_OFS_EVENT_FLAG, 1'b0, 32'h80, "read done");
        osc <= 1'b1;
        repeat (6) @(posedge i_clk);
        rc(`RTC_OFS_STATUS, 1'b0, 32'h1, "osc status");
        wr(`RTC_OFS_XFER_CTRL, 32'h23);
        chk("osc stopped", 32'h20, {26'h0, stb});
        osc <= 1'b0;
        // Buffers are only written while no setting transfer is pending
        chk("pending idle", 32'h0, {31'h0, pend});
        // Minute matches, hour differs but is not compared
        wr(`RTC_OFS_ALARM_VALUE, 32'h0000_5534);
        wr(`RTC_OFS_ALARM_CMP_EN, 32'h01);
        cnt <= 40'h00_0000_1234;
        repeat (4) @(posedge i_clk);
        rc(`RTC_OFS_EVENT_FLAG, 1'b0, 32'hA0, "alarm match");
        rc(`RTC_OFS_ALARM_CMP_EN, 1'b0, 32'h01, "compare enables");
        // Year field is not compared, so writing it leaves the match alone
        wr(`RTC_OFS_ALARM_CMP_HI, 32'h12);
        rc(`RTC_OFS_ALARM_CMP_HI, 1'b0, 32'h12, "alarm year");
        second_pulse_detect_stop <= 1'b1;
        rewr <= 1'b1;
        repeat (3) @(posedge i_clk);
        wend <= 1'b1;
        @(posedge i_clk);
        wend <= 1'b0;
        rc(`RTC_OFS_EVENT_FLAG, 1'b0, 32'hE0, "rewrite error");
        // A second that counts during the rewrite is no error
        wr(`RTC_OFS_EVENT_FLAG, 32'hBF);
        tick(1);
        @(posedge i_clk);
        wend <= 1'b1;
        @(posedge i_clk);
        wend <= 1'b0;
        rc(`RTC_OFS_EVENT_FLAG, 1'b0, 32'hA2, "rewrite ok");
        end_sim();
    end
endmodule
`default_nettype wire
